// ===== pkg/can_rx_cfg.svh
// Constants of the receive mailbox path: offsets, fields, codes, reset values
`ifndef CAN_RX_CFG_SVH
`define CAN_RX_CFG_SVH
`define CRX_NUM_MB 4
`define CRX_MB_IDX_W 2
`define CRX_FLAG_W 11
`define CRX_FLAG_ERR 8
`define CRX_FLAG_RETX 9
`define CRX_FLAG_OVF 10
`define CRX_MCR_OFS 12'h000
`define CRX_CTRL1_OFS 12'h004
`define CRX_CBT_OFS 12'h008
`define CRX_FDCBT_OFS 12'h00C
`define CRX_ENHANCED_FIFO_CONTROL_REGISTER_OFS 12'h010
`define CRX_FLAG_OFS 12'h014
`define CRX_MASK_OFS 12'h018
`define CRX_TIMER_OFS 12'h01C
`define CRX_MB_BASE 12'h020
`define CRX_MB_STRIDE 12'h008
`define CRX_CS_BUSY_BIT 28
`define CRX_CS_CODE_LSB 24
`define CRX_CBT_SEL_BIT 31
`define CRX_ENHANCED_FIFO_CONTROL_REGISTER_EN_BIT 31
`define CRX_CODE_INACTIVE 4'h0
`define CRX_CODE_EMPTY 4'h4
`define CRX_CODE_FULL 4'h2
`define CRX_CODE_OVERRUN 4'h6
`define CRX_NOM_JW_RST 2'h0
`define CRX_EXT_JW_RST 5'h00
`define CRX_DATA_JW_RST 3'h0
`endif

// ===== pkg/can_rx_pkg.sv
// Types shared by the receive mailbox path
`include "can_rx_cfg.svh"
package can_rx_pkg;
   // Bit-level events from the protocol engine
   typedef struct packed {
      logic sample;
      logic value;
      logic crc_delim;
      logic fd_brs;
      logic dom_edge;
      logic tx_role;
      logic err_seen;
   } bit_evt_t;
   // One received frame after acceptance filtering
   typedef struct packed {
      logic [10:0] id;
      logic [31:0] data;
      logic [`CRX_MB_IDX_W-1:0] mb_idx;
      logic to_fifo;
   } frame_t;
   // Frame with its valid flag
   typedef struct packed {
      logic valid;
      frame_t frame;
   } stage_t;
   // APB request signals from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   // Receive mailbox contents
   typedef struct packed {
      logic [3:0] code;
      logic [10:0] id;
      logic [31:0] data;
   } mailbox_t;
endpackage : can_rx_pkg

// ===== verilog/can_fd_receive_mailbox_path.sv
// Receive path: jump width select, staging buffers, mailboxes, APB registers
// Contract
// [R1] FD frame with bit rate switch uses data phase jump width at CRC delimiter.
// [R2] Nominal jump width comes from control register one or extended field.
// [R3] Data phase jump width comes from the fd bit timing register field.
// [R4] Resync only on unexpected dominant; dominant CRC delimiter raises error frame.
// [R5] Transmitter seeing an error frame on its frame retransmits it.
// [R6] Frame for a locked mailbox stays in the first staging buffer.
// [R7] With first buffer busy, next frame goes to second buffer and is routed.
// [R8] On unlock the held frame moves in with the proper received code.
// [R9] Code field selects mailbox kind; inactive mailbox takes no frames.
// [R10] Legacy FIFO works only with its enable bit; otherwise mailboxes only.
// [R11] Enhanced FIFO has its own enable and coexists with mailboxes.
// [R12] Software reads status word, polls busy, reads data, clears flag, reads timer.
// [R13] Timer register read releases the current mailbox lock.
// [R14] Busy bit is clear when the mailbox is not locked or updating.
// [R15] Software keeps a mailbox locked no longer than 20 bit times.
// [R16] Status word read locks the mailbox until timer read or other lock.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "can_rx_cfg.svh"
module can_fd_receive_mailbox_path #(
   parameter int NUM_MB = `CRX_NUM_MB
) (
   input wire logic i_clk,                       // 50 MHz clock
   input wire logic i_rst,                       // Async reset, active high
   input wire can_rx_pkg::apb_req_t i_apb,       // APB request
   output logic [31:0] o_prdata,                 // APB read data
   output logic o_pready,                        // APB ready
   output logic o_pslverr,                       // APB error, unmapped address
   input wire can_rx_pkg::bit_evt_t i_bit,       // Bit events from engine
   input wire can_rx_pkg::stage_t i_rx,          // Received frame strobe
   output logic [4:0] o_sjw,                     // Jump width in force
   output logic o_resync,                        // Resync applied pulse
   output logic o_err_frame,                     // Error frame request pulse
   output logic o_retx,                          // Retransmit request pulse
   output can_rx_pkg::stage_t o_fifo,            // FIFO push pulse with frame
   output logic o_irq                            // Interrupt level
);
   import can_rx_pkg::*;
   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic legacy_en;
      logic enh_en;
      logic [1:0] nom_jw;
      logic [4:0] ext_jw;
      logic ext_sel;
      logic [2:0] data_jw;
      logic [`CRX_FLAG_W-1:0] flags;
      logic [`CRX_FLAG_W-1:0] mask;
      logic irq;
      logic [15:0] timer;
      logic lock_v;
      logic [`CRX_MB_IDX_W-1:0] lock_idx;
      stage_t sb0;
      stage_t sb1;
      stage_t fifo;
      logic [4:0] sjw;
      logic resync;
      logic err_frame;
      logic retx;
      mailbox_t [NUM_MB-1:0] mb;
   } state_t;
   state_t r;
   state_t n;
   logic acc;
   logic fin;
   logic [11:0] mb_ofs;
   logic mb_hit;
   logic [`CRX_MB_IDX_W-1:0] mbk;
   logic [31:0] rd;
   logic hit;
   logic [NUM_MB-1:0] busy;
   logic fifo_en;
   logic fifo0;
   logic fifo1;
   logic locked0;
   logic locked1;
   logic d0;
   logic d1;
   logic dgo;
   frame_t dsel;
   logic [4:0] nom;
   logic err_now;
   // Mailbox window decode
   assign mb_ofs = i_apb.paddr - `CRX_MB_BASE;
   assign mb_hit = (i_apb.paddr >= `CRX_MB_BASE) & (i_apb.paddr[1:0] == 2'h0)
                   & (mb_ofs < 12'(NUM_MB * 8));
   assign mbk = mb_ofs[`CRX_MB_IDX_W+2:3];
   assign acc = i_apb.psel & i_apb.penable;
   assign fin = acc & r.pready;
   // Routing of the two staging buffers
   assign fifo_en = r.legacy_en | r.enh_en;                       // [R10] [R11]
   assign fifo0 = r.sb0.frame.to_fifo & fifo_en;
   assign fifo1 = r.sb1.frame.to_fifo & fifo_en;
   assign locked0 = r.lock_v & (r.lock_idx == r.sb0.frame.mb_idx);
   assign locked1 = r.lock_v & (r.lock_idx == r.sb1.frame.mb_idx);
   assign d0 = r.sb0.valid & (fifo0 | ~locked0);                  // [R6]
   assign d1 = r.sb1.valid & ~d0 & (fifo1 | ~locked1);            // [R7]
   assign dgo = d0 | d1;
   assign dsel = d0 ? r.sb0.frame : r.sb1.frame;
   // Busy per mailbox: locked with a frame waiting for it
   genvar k;
   generate
      for (k = 0; k < NUM_MB; k++)
      begin : g_busy
         assign busy[k] = r.lock_v & (r.lock_idx == `CRX_MB_IDX_W'(k))
                          & ((r.sb0.valid & ~fifo0 & (r.sb0.frame.mb_idx == `CRX_MB_IDX_W'(k)))
                          | (r.sb1.valid & ~fifo1
                          & (r.sb1.frame.mb_idx == `CRX_MB_IDX_W'(k)))); // [R14]
      end
   endgenerate
   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      n = r;
      rd = 32'h0000_0000;
      hit = 1'b1;
      n.pready = 1'b0;
      n.fifo.valid = 1'b0;
      n.timer = r.timer + 16'h0001;
      // Read mux
      case (i_apb.paddr)
         `CRX_MCR_OFS: rd = {31'h0, r.legacy_en};
         `CRX_CTRL1_OFS: rd = {30'h0, r.nom_jw};
         `CRX_CBT_OFS: rd = {r.ext_sel, 26'h0, r.ext_jw};
         `CRX_FDCBT_OFS: rd = {29'h0, r.data_jw};
         `CRX_ENHANCED_FIFO_CONTROL_REGISTER_OFS: rd = {r.enh_en, 31'h0};
         `CRX_FLAG_OFS: rd = {21'h0, r.flags};
         `CRX_MASK_OFS: rd = {21'h0, r.mask};
         `CRX_TIMER_OFS: rd = {16'h0, r.timer};
         default:
         begin
            if (mb_hit & ~i_apb.paddr[2])
               rd = {3'h0, busy[mbk], r.mb[mbk].code, 13'h0, r.mb[mbk].id};
            else if (mb_hit)
               rd = r.mb[mbk].data;
            else
               hit = 1'b0;
         end
      endcase
      // One wait state, answer registered
      if (acc & ~r.pready)
      begin
         n.pready = 1'b1;
         n.prdata = i_apb.pwrite ? 32'h0000_0000 : rd;
         n.pslverr = ~hit;
      end
      // Read side effects at completion
      if (fin & ~i_apb.pwrite & mb_hit & ~i_apb.paddr[2])
      begin
         n.lock_v = 1'b1;                                          // [R16]
         n.lock_idx = mbk;
      end
      if (fin & ~i_apb.pwrite & (i_apb.paddr == `CRX_TIMER_OFS))
         n.lock_v = 1'b0;                                          // [R13]
      // Register writes at completion
      if (fin & i_apb.pwrite)
      begin
         case (i_apb.paddr)
            `CRX_MCR_OFS: n.legacy_en = i_apb.pwdata[0];
            `CRX_CTRL1_OFS: n.nom_jw = i_apb.pwdata[1:0];
            `CRX_CBT_OFS:
            begin
               n.ext_sel = i_apb.pwdata[`CRX_CBT_SEL_BIT];
               n.ext_jw = i_apb.pwdata[4:0];
            end
            `CRX_FDCBT_OFS: n.data_jw = i_apb.pwdata[2:0];
            `CRX_ENHANCED_FIFO_CONTROL_REGISTER_OFS: n.enh_en = i_apb.pwdata[`CRX_ENHANCED_FIFO_CONTROL_REGISTER_EN_BIT];
            `CRX_FLAG_OFS: n.flags = r.flags & ~i_apb.pwdata[`CRX_FLAG_W-1:0];
            `CRX_MASK_OFS: n.mask = i_apb.pwdata[`CRX_FLAG_W-1:0];
            default:
            begin
               if (mb_hit & ~i_apb.paddr[2])
               begin
                  n.mb[mbk].code = i_apb.pwdata[`CRX_CS_CODE_LSB+3:`CRX_CS_CODE_LSB];
                  n.mb[mbk].id = i_apb.pwdata[10:0];
               end
               else if (mb_hit)
                  n.mb[mbk].data = i_apb.pwdata;
            end
         endcase
      end
      // Jump width select
      nom = r.ext_sel ? r.ext_jw : {3'h0, r.nom_jw};                // [R2]
      n.sjw = (i_bit.crc_delim & i_bit.fd_brs) ? {2'h0, r.data_jw} : nom; // [R1] [R3]
      n.resync = i_bit.dom_edge;                                    // [R4]
      err_now = i_bit.sample & i_bit.crc_delim & ~i_bit.value;
      n.err_frame = err_now;                                        // [R4]
      n.retx = i_bit.tx_role & (i_bit.err_seen | err_now);          // [R5]
      // Delivery of one staged frame per cycle
      if (dgo)
      begin
         if (dsel.to_fifo & fifo_en)
         begin
            n.fifo.valid = 1'b1;                                    // [R10] [R11]
            n.fifo.frame = dsel;
         end
         else
         begin
            case (r.mb[dsel.mb_idx].code)
               `CRX_CODE_EMPTY,
               `CRX_CODE_FULL,
               `CRX_CODE_OVERRUN:
               begin
                  n.mb[dsel.mb_idx].code = (r.mb[dsel.mb_idx].code == `CRX_CODE_EMPTY)
                                           ? `CRX_CODE_FULL : `CRX_CODE_OVERRUN; // [R8]
                  n.mb[dsel.mb_idx].id = dsel.id;
                  n.mb[dsel.mb_idx].data = dsel.data;
                  n.flags[dsel.mb_idx] = 1'b1;
               end
               default: n.mb[dsel.mb_idx].code = r.mb[dsel.mb_idx].code; // [R9]
            endcase
         end
      end
      if (d0)
         n.sb0.valid = 1'b0;
      if (d1)
         n.sb1.valid = 1'b0;
      // Incoming frame into a free staging buffer
      if (i_rx.valid)
      begin
         if (~n.sb0.valid)
            n.sb0 = i_rx;
         else if (~n.sb1.valid)
            n.sb1 = i_rx;                                           // [R7]
         else
            n.flags[`CRX_FLAG_OVF] = 1'b1;
      end
      // Events set after clears so a set wins
      if (err_now)
         n.flags[`CRX_FLAG_ERR] = 1'b1;
      if (n.retx)
         n.flags[`CRX_FLAG_RETX] = 1'b1;
      n.irq = |(n.flags & n.mask);
   end
   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= '0;
         r.nom_jw <= `CRX_NOM_JW_RST;
         r.ext_jw <= `CRX_EXT_JW_RST;
         r.data_jw <= `CRX_DATA_JW_RST;
      end
      else
         r <= n;
   end
   // Outputs straight from the state
   assign o_prdata = r.prdata;
   assign o_pready = r.pready;
   assign o_pslverr = r.pslverr;
   assign o_sjw = r.sjw;
   assign o_resync = r.resync;
   assign o_err_frame = r.err_frame;
   assign o_retx = r.retx;
   assign o_fifo = r.fifo;
   assign o_irq = r.irq;
   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_cs_read;
      fin & ~i_apb.pwrite & mb_hit & ~i_apb.paddr[2];
   endsequence
   sequence s_timer_read;
      fin & ~i_apb.pwrite & (i_apb.paddr == `CRX_TIMER_OFS);
   endsequence
   sequence s_held;
      r.sb0.valid & ~fifo0 & locked0 & (r.mb[r.sb0.frame.mb_idx].code == `CRX_CODE_EMPTY);
   endsequence
   property p_sjw_data;
      i_bit.crc_delim & i_bit.fd_brs |=> o_sjw == {2'h0, $past(r.data_jw)};
   endproperty
   a_sjw_data: assert property (p_sjw_data) else $error("data jump width not used"); // [R1] [R3]
   property p_sjw_nom;
      ~(i_bit.crc_delim & i_bit.fd_brs)
      |=> o_sjw == ($past(r.ext_sel) ? $past(r.ext_jw) : {3'h0, $past(r.nom_jw)});
   endproperty
   a_sjw_nom: assert property (p_sjw_nom) else $error("nominal jump width wrong"); // [R2]
   property p_err;
      i_bit.sample & i_bit.crc_delim & ~i_bit.value |=> o_err_frame ##1 ~o_err_frame[*1];
   endproperty
   a_err: assert property (p_err) else $error("no error frame on bad delimiter"); // [R4]
   property p_resync;
      o_resync |-> $past(i_bit.dom_edge);
   endproperty
   a_resync: assert property (p_resync) else $error("resync without dominant edge"); // [R4]
   property p_retx;
      i_bit.tx_role & i_bit.err_seen |=> o_retx;
   endproperty
   a_retx: assert property (p_retx) else $error("retransmit missing"); // [R5]
   property p_hold;
      r.sb0.valid & ~fifo0 & locked0 |=> r.sb0.valid & (r.sb0.frame == $past(r.sb0.frame));
   endproperty
   a_hold: assert property (p_hold) else $error("held frame left first buffer"); // [R6]
   property p_second;
      r.sb0.valid & ~d0 & ~r.sb1.valid & i_rx.valid |=> r.sb1.valid;
   endproperty
   a_second: assert property (p_second) else $error("second buffer not loaded"); // [R7]
   property p_release;
      s_held ##1 (~r.lock_v & ~fin)
      |=> r.mb[$past(r.sb0.frame.mb_idx, 2)].code == `CRX_CODE_FULL;
   endproperty
   a_release: assert property (p_release) else $error("held frame not delivered"); // [R8]
   property p_inactive;
      dgo & ~(dsel.to_fifo & fifo_en) & ~fin
      & (r.mb[dsel.mb_idx].code == `CRX_CODE_INACTIVE)
      |=> r.mb[$past(dsel.mb_idx)].code == `CRX_CODE_INACTIVE;
   endproperty
   a_inactive: assert property (p_inactive) else $error("inactive mailbox changed"); // [R9]
   property p_fifo_en;
      o_fifo.valid |-> $past(r.legacy_en | r.enh_en);
   endproperty
   a_fifo_en: assert property (p_fifo_en) else $error("fifo push while disabled"); // [R10] [R11]
   property p_lock;
      s_cs_read |=> r.lock_v & (r.lock_idx == $past(mbk));
   endproperty
   a_lock: assert property (p_lock) else $error("status read did not lock"); // [R16]
   property p_unlock;
      s_timer_read |=> ~r.lock_v;
   endproperty
   a_unlock: assert property (p_unlock) else $error("timer read did not unlock"); // [R13]
   property p_busy;
      fin & ~i_apb.pwrite & mb_hit & ~i_apb.paddr[2] & ~$past(r.lock_v)
      |-> ~o_prdata[`CRX_CS_BUSY_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("busy while unlocked"); // [R14]
endmodule : can_fd_receive_mailbox_path

// ===== tb/can_node_model.sv
// Model of the other bus nodes: bit events and accepted frames
`timescale 1ns/100ps
module can_node_model
(
   input wire logic i_clk,              // Bench clock
   output can_rx_pkg::bit_evt_t o_bit,  // Bit events to the receiver
   output can_rx_pkg::stage_t o_rx      // Frames to the receiver
);
   import can_rx_pkg::*;
   // Idle bus: no events, no frame
   initial
   begin
      o_bit = '0;
      o_rx = '0;
   end
   // Set bit event levels after an edge; pulses end with the next call
   task automatic put(input bit_evt_t e);
      @(posedge i_clk);
      o_bit <= e;
   endtask : put
   // One frame strobe; the frame lines show the inverse once released
   task automatic send(input logic [10:0] id, input logic [31:0] d,
      input logic [1:0] mb, input logic f);
      @(posedge i_clk);
      o_rx <= '{1'b1, '{id, d, mb, f}};
      @(posedge i_clk);
      o_rx <= '{1'b0, '{~id, ~d, ~mb, ~f}};
   endtask : send
endmodule : can_node_model

// ===== tb/tb_top.sv
// Self-checking bench of the receive mailbox path
`timescale 1ns/100ps
module tb_top;
   import can_rx_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   apb_req_t apb_r = '0;
   logic [31:0] o_prdata, rd;
   logic o_pready, o_pslverr, o_resync, o_err_frame, o_retx, o_irq, er;
   logic [4:0] o_sjw;
   stage_t o_fifo, rx;
   frame_t ff;
   bit_evt_t bits;
   int n_fail = 0;
   int checked = 0;
   int n_res = 0;
   int n_err = 0;
   int n_retx = 0;
   int n_fifo = 0;
   // *****************************
   // Clock, instances, pulse counters
   // *****************************
   always #10 i_clk = ~i_clk;
   can_node_model node (.i_clk(i_clk), .o_bit(bits), .o_rx(rx));
   can_fd_receive_mailbox_path uut (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb_r),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_bit(bits),
      .i_rx(rx), .o_sjw(o_sjw), .o_resync(o_resync), .o_err_frame(o_err_frame),
      .o_retx(o_retx), .o_fifo(o_fifo), .o_irq(o_irq));
   // Count output pulses, keep the last pushed frame
   always @(posedge i_clk)
   begin
      n_res <= n_res + int'(o_resync === 1'b1);
      n_err <= n_err + int'(o_err_frame === 1'b1);
      n_retx <= n_retx + int'(o_retx === 1'b1);
      n_fifo <= n_fifo + int'(o_fifo.valid === 1'b1);
      if (o_fifo.valid === 1'b1)
         ff <= o_fifo.frame;
   end
   // *****************************
   // Shared tasks
   // *****************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      apb_r <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      apb_r.penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_pready !== 1'b1 && n < 20);
      if (n == 20)
         n_fail++;
      rd = o_prdata;
      er = o_pslverr;
      apb_r <= '0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   // Software service: status with busy poll, data, flag clear, unlock
   task automatic service(input logic [1:0] k, input logic [31:0] cs, input logic [31:0] d);
      int t;
      t = 0;
      do
      begin
         apb(1'b0, 12'h020 + {7'h0, k, 3'h0}, 32'h0);
         t++;
      end
      while (rd[28] === 1'b1 && t < 4);
      chk(rd, cs);
      rdc(12'h024 + {7'h0, k, 3'h0}, d);
      wr(12'h014, 32'h1 << k);
      apb(1'b0, 12'h01C, 32'h0);
   endtask : service
   task automatic test_done;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   // *****************************
   // Scenarios
   // *****************************
   task automatic t_regs;
      rdc(12'h004, 32'h0);
      wr(12'h004, 32'h3);
      rdc(12'h004, 32'h3);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("regs test done");
   endtask : t_regs
   // Jump width chosen by delimiter and bit rate switch
   task automatic t_sjw;
      wr(12'h00C, 32'h5);
      node.put(7'h18);
      repeat (2) @(posedge i_clk);
      chk({27'h0, o_sjw}, 32'h5);
      node.put(7'h10);
      repeat (2) @(posedge i_clk);
      chk({27'h0, o_sjw}, 32'h3);
      wr(12'h008, 32'h8000_0011);
      repeat (2) @(posedge i_clk);
      chk({27'h0, o_sjw}, 32'h11);
      node.put(7'h18);
      repeat (2) @(posedge i_clk);
      chk({27'h0, o_sjw}, 32'h5);
      node.put(7'h0);
      $display("jump width test done");
   endtask : t_sjw
   // Resync, delimiter error, retransmit, flags and interrupt
   task automatic t_err;
      int a, b, c;
      a = n_res;
      b = n_err;
      c = n_retx;
      node.put(7'h04);
      node.put(7'h70);
      node.put(7'h50);
      node.put(7'h03);
      node.put(7'h00);
      repeat (3) @(posedge i_clk);
      chk(n_res - a, 1);
      chk(n_err - b, 1);
      chk(n_retx - c, 1);
      rdc(12'h014, 32'h300);
      chk({31'h0, o_irq}, 32'h0);
      wr(12'h018, 32'h100);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_irq}, 32'h1);
      wr(12'h014, 32'h300);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_irq}, 32'h0);
      wr(12'h018, 32'h0);
      $display("error test done");
   endtask : t_err
   // Lock, hold in first buffer, second buffer routing, unlock delivery
   task automatic t_lock;
      int f;
      wr(12'h020, 32'h0400_0000);
      wr(12'h028, 32'h0400_0000);
      node.send(11'h123, 32'hA5A5_0001, 2'd0, 1'b0);
      repeat (4) @(posedge i_clk);
      rdc(12'h020, 32'h0200_0123);
      rdc(12'h024, 32'hA5A5_0001);
      wr(12'h000, 32'h1);
      f = n_fifo;
      node.send(11'h456, 32'h5A5A_0002, 2'd0, 1'b0);
      node.send(11'h077, 32'h1, 2'd1, 1'b1);
      repeat (4) @(posedge i_clk);
      chk(n_fifo - f, 1);
      chk({21'h0, ff.id}, 32'h077);
      rdc(12'h020, 32'h1200_0123);
      wr(12'h020, 32'h0400_0000);
      apb(1'b0, 12'h01C, 32'h0);
      repeat (4) @(posedge i_clk);
      service(2'd0, 32'h0200_0456, 32'h5A5A_0002);
      $display("lock test done");
   endtask : t_lock
   // FIFO enables and inactive mailbox
   task automatic t_fifo;
      int f;
      wr(12'h000, 32'h0);
      f = n_fifo;
      node.send(11'h0AA, 32'h2, 2'd1, 1'b1);
      repeat (4) @(posedge i_clk);
      chk(n_fifo - f, 0);
      rdc(12'h028, 32'h0200_00AA);
      wr(12'h010, 32'h8000_0000);
      node.send(11'h0BB, 32'h3, 2'd1, 1'b1);
      repeat (4) @(posedge i_clk);
      chk(n_fifo - f, 1);
      chk(ff.data, 32'h3);
      node.send(11'h0DD, 32'h5, 2'd1, 1'b0);
      repeat (4) @(posedge i_clk);
      rdc(12'h028, 32'h1200_00AA);
      apb(1'b0, 12'h01C, 32'h0);
      repeat (4) @(posedge i_clk);
      rdc(12'h028, 32'h0600_00DD);
      wr(12'h014, 32'h7FF);
      node.send(11'h0CC, 32'h4, 2'd2, 1'b0);
      repeat (4) @(posedge i_clk);
      rdc(12'h014, 32'h0);
      rdc(12'h030, 32'h0);
      $display("fifo test done");
   endtask : t_fifo
   // *****************************
   // Main sequence and watchdog
   // *****************************
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      t_sjw();
      t_err();
      t_lock();
      t_fifo();
      test_done();
   end
   // Cut a hang short
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      test_done();
   end
endmodule : tb_top
